//--- fdc_pkg.sv
// Purpose: shared constants and carriers for the floppy controller host port
// Assumes: 50 MHz ref_clk, byte registers on even module offsets
// Notes:   two design files hold all logic
package fdc_pkg;
   localparam logic [3:0] OFF_STATUS_CMD = 4'h0;
   localparam logic [3:0] OFF_TRACK      = 4'h2;
   localparam logic [3:0] OFF_SECTOR     = 4'h4;
   localparam logic [3:0] OFF_DATA       = 4'h6;
   localparam logic [3:0] OFF_DRIVE_CTRL = 4'h8;
   localparam logic [7:0] CMD_RESET_VAL  = 8'h03;
   localparam logic [7:0] SECTOR_RESET   = 8'h01;
   localparam logic [7:0] ZONE_LO        = 8'h2c;
   localparam logic [7:0] ZONE_HI        = 8'h4c;
   localparam int         ST_NOT_READY   = 7;
   localparam int         ST_PROTECT     = 6;
   localparam int         ST_TRACK0      = 2;
   localparam int         ST_BUSY        = 0;
   localparam int         ST_SERVICE     = 1;
   localparam int         DC_DRIVE0      = 0;
   localparam int         DC_MOTOR       = 2;
   localparam int         DC_SIDE        = 5;
   localparam int         DC_FAST        = 6;
   localparam int         DC_RESET       = 7;
   localparam int         CLK_MHZ        = 50;
   localparam int         PULSE_NS       = 250;
   localparam int         REF_PERIOD_NS  = 1000 / CLK_MHZ;
   localparam logic [3:0] PULSE_CYC      = 4'((PULSE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
   localparam logic [4:0] DIV10_TERM     = 5'(CLK_MHZ / 10 - 1);
   localparam logic [2:0] DIV2M_TERM     = 3'h4;
   localparam logic [4:0] SEEK_STEP_CYC  = 5'h1f;
   localparam logic [2:0] BITS_PER_BYTE  = 3'h7;
   localparam logic [7:0] WRITE_BYTES    = 8'h08;
   typedef struct packed {
      logic       sel_n;
      logic       rd_n;
      logic       wr_n;
      logic [3:0] addr;
      logic [7:0] wdata;
   } fdc_bus_t;
   typedef struct packed {
      logic ready;
      logic protect_n;
      logic track0_n;
      logic index_n;
      logic read_n;
   } fdc_drive_in_t;
endpackage

//--- fdc_fifo.sv
// Purpose: small byte fifo in the data path
// Assumes: single clock, synchronous active-low reset
// Notes:   depth must be a power of two
module fdc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   logic             push;
   logic             pop;
   assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign out_data  = mem[rd_ptr_reg[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!reset_n || flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

//--- fdc_host_port.sv
// Purpose: floppy controller register port and drive-side control
// Assumes: bus strobes synchronous to ref_clk, one cycle per access
// Notes:   simplified formatter; the fifo sits between disk and data register
// Overview of operation
// - two select bits pick status/cmd, track, sector, data
// - select only for module offsets zero through seven
// - reset loads command 03h, sector 01h, restores
// - one step pulse per track crossed
// - direction high stepping inward, low outward
// - same clock for writes and seeks, rate set by control bit 6, reads paced by read-data edges
// - inner zone flag for tracks 44..76 during transfers
// - 260 ns write pulse per flux transition, 250 ns rounded up to 13 ref cycles
// - read/write skipped with interrupt when not ready
// - positioning commands ignore drive ready
// - status bit 7 is inverted drive ready, forced low while control bit 7 holds master reset
// - write protected aborts write, sets protect flag
// - service request on full read/empty write data
// - irq on completion, cleared by status read/command write
// - each low read pulse is one flux transition
// - double density encoding always used
// - service request forwarded as priority-4 dma request
// - completion forwarded as priority-5 bus interrupt
// - control bit 6 picks fast clock
// - fast clock from 10 MHz counter, slow halves it
// - head load looped into head load timing
// - precompensation enabled with inner zone flag
// - control bit 7 drives controller master reset
// - control bits select drive, motor, side
module fdc_host_port (
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   input  wire fdc_pkg::fdc_bus_t      bus,
   output logic                  [7:0] rdata,
   input  wire fdc_pkg::fdc_drive_in_t drv,
   output logic                        byte_service_request,
   output logic                        command_done_irq,
   output logic                        bus_dma_request_p4_n,
   output logic                        bus_interrupt_p5_n,
   output logic                        step_out,
   output logic                        head_travel_direction,
   output logic                        write_gate_out,
   output logic                        flux_write_pulse,
   output logic                        head_load_out,
   output logic                        inner_track_zone,
   output logic                        precomp_enable,
   output logic                        double_density,
   output logic                        floppy_ctrl_clock,
   output logic                        drive0_select_n,
   output logic                        motor_on_n,
   output logic                        head_side_choice_n
);
   typedef enum logic [2:0] {S_IDLE, S_SEEK, S_SETTLE, S_READ, S_WRITE, S_DONE} fdc_state_t;

   function automatic logic in_zone(input logic [7:0] t);
      in_zone = (t >= fdc_pkg::ZONE_LO) && (t <= fdc_pkg::ZONE_HI);
   endfunction

   fdc_state_t state_reg;
   logic [7:0] command_reg, track_reg, sector_reg, data_reg, target_reg, drive_ctrl_reg;
   logic [7:0] shift_reg, count_reg;
   logic [2:0] bit_cnt_reg;
   logic       not_ready_reg, protect_reg, drq_reg, irq_reg, restore_reg;
   logic [4:0] step_cnt_reg;
   logic [3:0] pulse_cnt_reg;
   logic [4:0] div10_reg;
   logic       clk10_reg;
   logic [2:0] div2_reg;
   logic       clk2_reg, clk1_reg, clk10_d_reg, clk2_d_reg, tick_reg;
   logic       read_d_reg;
   logic       mr_n;
   logic       floppy_ctrl_select_n, register_read_strobe_n, reg_select_lo, reg_select_hi;
   logic       rd_acc, wr_acc;
   logic       fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [7:0] fifo_in_data, fifo_out_data;
   logic       flux_edge, fast;

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   assign floppy_ctrl_select_n   = bus.sel_n || bus.addr[3];
   assign register_read_strobe_n = bus.rd_n;
   assign reg_select_lo          = bus.addr[1];
   assign reg_select_hi          = bus.addr[2];
   assign rd_acc = !floppy_ctrl_select_n && !register_read_strobe_n;
   assign wr_acc = !floppy_ctrl_select_n && !bus.wr_n;
   assign mr_n   = reset_n && drive_ctrl_reg[fdc_pkg::DC_RESET];

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         drive_ctrl_reg <= 8'h00;
      end else if (!bus.sel_n && !bus.wr_n && bus.addr == fdc_pkg::OFF_DRIVE_CTRL) begin
         drive_ctrl_reg <= bus.wdata;
      end
   end

   always_comb begin
      rdata = 8'h00;
      if (rd_acc) begin
         unique case ({reg_select_hi, reg_select_lo})
            2'b00: rdata = {mr_n && !drv.ready, protect_reg, 3'b000, !drv.track0_n,
                            drq_reg, state_reg != S_IDLE};
            2'b01: rdata = track_reg;
            2'b10: rdata = sector_reg;
            2'b11: rdata = data_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock generation: 10 MHz from ref, 2 MHz by counter, 1 MHz halved
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         div10_reg <= '0;
         clk10_reg <= 1'b0;
      end else if (div10_reg == fdc_pkg::DIV10_TERM) begin
         div10_reg <= '0;
         clk10_reg <= 1'b1;
      end else begin
         // ref is an odd multiple of 10 MHz, so two-of-five duty, not square
         div10_reg <= div10_reg + 1'b1;
         clk10_reg <= (div10_reg == 5'h00);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         div2_reg    <= '0;
         clk2_reg    <= 1'b0;
         clk1_reg    <= 1'b0;
         clk10_d_reg <= 1'b0;
         clk2_d_reg  <= 1'b0;
      end else begin
         clk10_d_reg <= clk10_reg;
         clk2_d_reg  <= clk2_reg;
         if (clk10_reg && !clk10_d_reg) begin
            div2_reg <= (div2_reg == fdc_pkg::DIV2M_TERM) ? 3'h0 : div2_reg + 1'b1;
            clk2_reg <= (div2_reg < 3'h2);
         end
         if (clk2_reg && !clk2_d_reg) begin
            clk1_reg <= !clk1_reg;
         end
      end
   end

   assign fast              = drive_ctrl_reg[fdc_pkg::DC_FAST];
   assign floppy_ctrl_clock = fast ? clk2_reg : clk1_reg;

   // controller work advances on rising edges of the selected clock
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= fast ? (clk2_reg && !clk2_d_reg) : (clk2_reg && !clk2_d_reg && !clk1_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read-data edge, one transition per low pulse
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         read_d_reg <= 1'b1;
      end else begin
         read_d_reg <= drv.read_n;
      end
   end
   assign flux_edge = read_d_reg && !drv.read_n;

   ////////////////////////////////////////////////////////////////////////
   // command engine
   always_ff @(posedge ref_clk) begin
      if (!mr_n) begin
         state_reg     <= S_IDLE;
         command_reg   <= fdc_pkg::CMD_RESET_VAL;
         sector_reg    <= fdc_pkg::SECTOR_RESET;
         track_reg     <= 8'hff;
         target_reg    <= 8'h00;
         restore_reg   <= 1'b1;
         protect_reg   <= 1'b0;
         step_cnt_reg  <= '0;
         count_reg     <= '0;
         bit_cnt_reg   <= '0;
         shift_reg     <= '0;
         step_out      <= 1'b0;
         head_travel_direction <= 1'b0;
      end else begin
         step_out <= 1'b0;
         if (wr_acc && {reg_select_hi, reg_select_lo} == 2'b01) begin
            track_reg <= bus.wdata;
         end
         if (wr_acc && {reg_select_hi, reg_select_lo} == 2'b10) begin
            sector_reg <= bus.wdata;
         end
         unique case (state_reg)
            S_IDLE: begin
               if (restore_reg) begin
                  restore_reg <= 1'b0;
                  target_reg  <= command_reg[4] ? data_reg : 8'h00;
                  state_reg   <= S_SEEK;
               end else if (wr_acc && {reg_select_hi, reg_select_lo} == 2'b00) begin
                  command_reg <= bus.wdata;
                  protect_reg <= 1'b0;
                  if (!bus.wdata[7]) begin
                     target_reg <= bus.wdata[4] ? data_reg : 8'h00;
                     state_reg  <= S_SEEK;
                  end else if (!drv.ready) begin
                     state_reg <= S_DONE;
                  end else if (bus.wdata[5] && !drv.protect_n) begin
                     protect_reg <= 1'b1;
                     state_reg   <= S_DONE;
                  end else begin
                     count_reg   <= fdc_pkg::WRITE_BYTES;
                     bit_cnt_reg <= '0;
                     state_reg   <= bus.wdata[5] ? S_WRITE : S_READ;
                  end
               end
            end
            S_SEEK: begin
               if (tick_reg) begin
                  step_cnt_reg <= step_cnt_reg + 1'b1;
                  if (step_cnt_reg == fdc_pkg::SEEK_STEP_CYC) begin
                     if (target_reg == 8'h00 && !drv.track0_n) begin
                        track_reg <= 8'h00;
                        state_reg <= S_SETTLE;
                     end else if (track_reg == target_reg && target_reg != 8'h00) begin
                        state_reg <= S_SETTLE;
                     end else begin
                        step_out <= 1'b1;
                        head_travel_direction <= target_reg > track_reg;
                        track_reg <= (target_reg > track_reg) ? track_reg + 1'b1 : track_reg - 1'b1;
                     end
                  end
               end
            end
            S_SETTLE: begin
               if (head_load_out) begin
                  state_reg <= S_DONE;
               end
            end
            S_READ: begin
               if (flux_edge && fifo_in_ready && count_reg != 8'h00) begin
                  shift_reg   <= {shift_reg[6:0], drv.index_n};
                  bit_cnt_reg <= bit_cnt_reg + 1'b1;
                  if (bit_cnt_reg == fdc_pkg::BITS_PER_BYTE) begin
                     count_reg <= count_reg - 1'b1;
                  end
               end else if (count_reg == 8'h00 && !fifo_out_valid && !drq_reg) begin
                  // last byte must reach the host before completion
                  state_reg <= S_DONE;
               end
            end
            S_WRITE: begin
               if (!drv.protect_n) begin
                  protect_reg <= 1'b1;
                  state_reg   <= S_DONE;
               end else if (fifo_out_valid && tick_reg && pulse_cnt_reg == 4'h0) begin
                  count_reg <= count_reg - 1'b1;
                  if (count_reg == 8'h01) begin
                     state_reg <= S_DONE;
                  end
               end
            end
            S_DONE: state_reg <= S_IDLE;
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // read byte goes into the fifo when the last bit lands
   assign fifo_in_valid  = (state_reg == S_READ) && flux_edge && (bit_cnt_reg == fdc_pkg::BITS_PER_BYTE);
   assign fifo_in_data   = {shift_reg[6:0], drv.index_n};
   assign fifo_out_ready = (state_reg == S_READ) ? !drq_reg :
                           (state_reg == S_WRITE) && tick_reg && pulse_cnt_reg == 4'h0;

   fdc_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .flush     (state_reg == S_IDLE),
      .in_valid  ((state_reg == S_WRITE) ? (wr_acc && {reg_select_hi, reg_select_lo} == 2'b11) : fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   ((state_reg == S_WRITE) ? bus.wdata : fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // data register and service request
   always_ff @(posedge ref_clk) begin
      if (!mr_n) begin
         data_reg <= 8'h00;
         drq_reg  <= 1'b0;
      end else begin
         if (wr_acc && {reg_select_hi, reg_select_lo} == 2'b11) begin
            data_reg <= bus.wdata;
         end else if (state_reg == S_READ && fifo_out_valid && !drq_reg) begin
            data_reg <= fifo_out_data;
         end
         if (state_reg == S_READ && fifo_out_valid && !drq_reg) begin
            drq_reg <= 1'b1;
         end else if (state_reg == S_WRITE && fifo_in_ready) begin
            drq_reg <= !(wr_acc && {reg_select_hi, reg_select_lo} == 2'b11);
         end else if ((rd_acc || wr_acc) && {reg_select_hi, reg_select_lo} == 2'b11) begin
            drq_reg <= 1'b0;
         end else if (state_reg == S_IDLE) begin
            drq_reg <= 1'b0;
         end
      end
   end

   // completion interrupt, set wins over a clearing access
   always_ff @(posedge ref_clk) begin
      if (!mr_n) begin
         irq_reg <= 1'b0;
      end else if (state_reg == S_DONE) begin
         irq_reg <= 1'b1;
      end else if ((rd_acc || wr_acc) && {reg_select_hi, reg_select_lo} == 2'b00) begin
         irq_reg <= 1'b0;
      end
   end

   assign byte_service_request = drq_reg;
   assign command_done_irq     = irq_reg;
   assign bus_dma_request_p4_n = !drq_reg;
   assign bus_interrupt_p5_n   = !irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // write stream: gate ahead of pulses, one fixed pulse per transition
   always_ff @(posedge ref_clk) begin
      if (!mr_n) begin
         pulse_cnt_reg    <= '0;
         flux_write_pulse <= 1'b0;
         write_gate_out   <= 1'b0;
         head_load_out    <= 1'b0;
      end else begin
         write_gate_out <= (state_reg == S_WRITE);
         head_load_out  <= (state_reg != S_IDLE) && (state_reg != S_DONE);
         if (state_reg == S_WRITE && write_gate_out && fifo_out_ready && fifo_out_valid) begin
            pulse_cnt_reg    <= fdc_pkg::PULSE_CYC;
            flux_write_pulse <= 1'b1;
         end else if (pulse_cnt_reg != 4'h0) begin
            pulse_cnt_reg    <= pulse_cnt_reg - 1'b1;
            flux_write_pulse <= (pulse_cnt_reg != 4'h1);
         end else begin
            flux_write_pulse <= 1'b0;
         end
      end
   end

   assign inner_track_zone   = ((state_reg == S_READ) || (state_reg == S_WRITE)) && in_zone(track_reg);
   assign precomp_enable     = inner_track_zone;
   assign double_density     = 1'b1;
   assign drive0_select_n    = !drive_ctrl_reg[fdc_pkg::DC_DRIVE0];
   assign motor_on_n         = !drive_ctrl_reg[fdc_pkg::DC_MOTOR];
   assign head_side_choice_n = !drive_ctrl_reg[fdc_pkg::DC_SIDE];
endmodule

//--- fdc_drive_model.sv
// Purpose: floppy drive model facing fdc_host_port
// Assumes: ref_clk domain, step pulses one cycle wide
// Notes:   head starts off track zero so restore must step
module fdc_drive_model (
   input  wire logic             ref_clk,
   input  wire logic             step_out,
   input  wire logic             head_travel_direction,
   input  wire logic             flux_write_pulse,
   input  wire logic             ready,
   input  wire logic             protect_n,
   output fdc_pkg::fdc_drive_in_t drv
);
   int         head_pos = 5;
   int         n_steps = 0;
   int         n_flux = 0;
   logic [9:0] tick = 10'h000;
   logic       fwp_q = 1'b0;
   ////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      tick <= tick + 10'h001;
      fwp_q <= flux_write_pulse;
      if (flux_write_pulse && !fwp_q) n_flux <= n_flux + 1;
      if (step_out) n_steps <= n_steps + 1;
      if (step_out && head_travel_direction) head_pos <= head_pos + 1;
      if (step_out && !head_travel_direction && head_pos > 0) head_pos <= head_pos - 1;
   end
   // wide flux pulses, so a 1 MHz sampler still sees each one
   assign drv = '{ready, protect_n, head_pos != 0, tick[9], tick[6]};
endmodule

//--- fdc_host_port_sva.sv
// Purpose: pin-level assertions for fdc_host_port
// Assumes: one ref_clk domain, sync active-low reset_n
// Notes:   bound into every fdc_host_port instance
module fdc_host_port_sva (
   input wire logic              ref_clk,
   input wire logic              reset_n,
   input wire fdc_pkg::fdc_bus_t bus,
   input wire logic              byte_service_request,
   input wire logic              command_done_irq,
   input wire logic              bus_dma_request_p4_n,
   input wire logic              bus_interrupt_p5_n,
   input wire logic              step_out,
   input wire logic              write_gate_out,
   input wire logic              flux_write_pulse,
   input wire logic              inner_track_zone,
   input wire logic              precomp_enable,
   input wire logic              drive0_select_n,
   input wire logic              head_side_choice_n,
   input wire logic              floppy_ctrl_clock
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic       st_rd, cmd_wr, dat_acc, ctl_wr;
   logic [3:0] pw_cnt;
   logic       ck_q, ck_rise, fast_q;
   logic [1:0] ck_seen;
   logic [6:0] ck_cnt;
   assign st_rd = !bus.sel_n && !bus.rd_n && bus.addr == fdc_pkg::OFF_STATUS_CMD;
   assign cmd_wr = !bus.sel_n && !bus.wr_n && bus.addr == fdc_pkg::OFF_STATUS_CMD;
   assign dat_acc = !bus.sel_n && !(bus.rd_n && bus.wr_n) && bus.addr == fdc_pkg::OFF_DATA;
   assign ctl_wr = !bus.sel_n && !bus.wr_n && bus.addr == fdc_pkg::OFF_DRIVE_CTRL;
   assign ck_rise = floppy_ctrl_clock && !ck_q;
   // rate switch may leave a short phase, so judge only from the third rise on
   always_ff @(posedge ref_clk) begin
      ck_q    <= floppy_ctrl_clock;
      ck_cnt  <= ck_rise ? 7'h00 : ck_cnt + 7'h01;
      ck_seen <= (!reset_n || ctl_wr) ? 2'h0 : (ck_rise && ck_seen != 2'h2) ? ck_seen + 2'h1 : ck_seen;
      fast_q  <= !reset_n ? 1'b0 : ctl_wr ? bus.wdata[fdc_pkg::DC_FAST] : fast_q;
   end
   // saturates, so a stuck pulse still fails the width check
   always_ff @(posedge ref_clk) begin
      pw_cnt <= (!reset_n || !flux_write_pulse) ? 4'h0 : (pw_cnt == 4'hf) ? pw_cnt : pw_cnt + 4'h1;
   end
   ////////////////////////////////////////
   property p_fwd; bus_dma_request_p4_n == !byte_service_request && bus_interrupt_p5_n == !command_done_irq; endproperty
   a_fwd: assert property (p_fwd) else $error("bus request copies wrong");
   property p_irq_clear; command_done_irq && st_rd |=> !command_done_irq; endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq kept after status read");
   property p_irq_hold; command_done_irq && !st_rd && !cmd_wr && !ctl_wr |=> command_done_irq; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unserviced");
   property p_drq_clear; byte_service_request && dat_acc |=> !byte_service_request; endproperty
   a_drq_clear: assert property (p_drq_clear) else $error("data request kept after access");
   property p_width; $fell(flux_write_pulse) |-> pw_cnt == fdc_pkg::PULSE_CYC; endproperty
   a_width: assert property (p_width) else $error("write pulse width wrong");
   property p_gate; $rose(flux_write_pulse) |-> write_gate_out && $past(write_gate_out); endproperty
   a_gate: assert property (p_gate) else $error("write pulse without prior gate");
   property p_precomp; precomp_enable == inner_track_zone; endproperty
   a_precomp: assert property (p_precomp) else $error("precomp not tied to zone");
   property p_ctrl; ctl_wr |=> drive0_select_n == !$past(bus.wdata[0]) && head_side_choice_n == !$past(bus.wdata[5]);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("drive control pins wrong");
   property p_clk_rate; ck_rise && ck_seen == 2'h2 |-> ck_cnt == (fast_q ? 7'h18 : 7'h31); endproperty
   a_clk_rate: assert property (p_clk_rate) else $error("controller clock period wrong");
   c_step: cover property (step_out);
   c_flux: cover property ($rose(flux_write_pulse));
   c_irq: cover property ($rose(command_done_irq));
endmodule
bind fdc_host_port fdc_host_port_sva fdc_host_port_sva_i (.*);

//--- test_fdc_host_port.sv
// Purpose: self-checking bench for fdc_host_port
// Assumes: 50 MHz ref_clk, drive model on the drive pins
// Notes:   seek targets kept short to bound the run
module test_fdc_host_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   ref_clk = 1'b0;
   logic                   reset_n = 1'b0;
   logic                   ready = 1'b0;
   logic                   prot_n = 1'b1;
   logic                   chk_r = 1'b0;
   fdc_pkg::fdc_bus_t      bus = '1;
   fdc_pkg::fdc_drive_in_t drv;
   logic [7:0]             rdata;
   logic                   drq, irq, itz, ds_n, mot_n, side_n, step, dir, fwp;
   logic [7:0]             exp_q[$];
   int                     error_cnt = 0;
   int                     n_checks = 0;
   fdc_host_port fdc_host_port_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .drv(drv),
      .byte_service_request(drq), .command_done_irq(irq), .bus_dma_request_p4_n(), .bus_interrupt_p5_n(),
      .step_out(step), .head_travel_direction(dir), .write_gate_out(), .flux_write_pulse(fwp), .head_load_out(),
      .inner_track_zone(itz), .precomp_enable(), .double_density(), .floppy_ctrl_clock(),
      .drive0_select_n(ds_n), .motor_on_n(mot_n), .head_side_choice_n(side_n));
   fdc_drive_model fdc_drive_model_i (.ref_clk(ref_clk), .step_out(step), .head_travel_direction(dir),
      .flux_write_pulse(fwp), .ready(ready), .protect_n(prot_n), .drv(drv));
   initial forever #10 ref_clk = ~ref_clk;
   ////////////////////////////////////////
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // released write data is inverted so a stale byte never looks valid
   task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic chk);
      @(posedge ref_clk);
      bus <= '{1'b0, wr, !wr, a, d};
      chk_r <= chk;
      @(posedge ref_clk);
      bus <= '{1'b1, 1'b1, 1'b1, a, ~d};
      chk_r <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 8'h00, 1'b1);
   endtask
   task automatic wait_hi(input logic use_irq, input int lim);
      repeat (lim) if (!(use_irq ? irq : drq)) @(negedge ref_clk);
      cmp({7'h00, use_irq ? irq : drq}, 8'h01);
   endtask
   task automatic xfer(input logic [7:0] cmd);
      acc(1'b1, fdc_pkg::OFF_STATUS_CMD, cmd, 1'b0);
      repeat (8) begin
         wait_hi(1'b0, 8000);
         cmp({7'h00, itz}, 8'h01);
         acc(cmd[5], fdc_pkg::OFF_DATA, 8'($urandom), 1'b0);
         @(negedge ref_clk);
         cmp({7'h00, drq}, 8'h00);
      end
      wait_hi(1'b1, 8000);
   endtask
   always @(negedge ref_clk) begin
      if (!bus.sel_n && !bus.rd_n && chk_r) cmp(rdata, exp_q.pop_front());
   end
   initial begin
      int tgt;
      void'($urandom(34103));
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(fdc_pkg::OFF_SECTOR, fdc_pkg::SECTOR_RESET);
      rd(fdc_pkg::OFF_STATUS_CMD, 8'h00);
      acc(1'b1, fdc_pkg::OFF_DRIVE_CTRL, 8'he5, 1'b0);
      @(negedge ref_clk);
      cmp({5'h00, ds_n, mot_n, side_n}, 8'h00);
      wait_hi(1'b1, 20000);
      cmp(8'(fdc_drive_model_i.head_pos), 8'h00);
      rd(fdc_pkg::OFF_STATUS_CMD, 8'h84);
      ready <= 1'b1;
      tgt = 44 + $urandom_range(3);
      acc(1'b1, fdc_pkg::OFF_TRACK, 8'h00, 1'b0);
      acc(1'b1, fdc_pkg::OFF_DATA, 8'(tgt), 1'b0);
      acc(1'b1, fdc_pkg::OFF_STATUS_CMD, 8'h10, 1'b0);
      wait_hi(1'b1, 60000);
      cmp(8'(fdc_drive_model_i.n_steps), 8'(tgt + 5));
      cmp(8'(fdc_drive_model_i.head_pos), 8'(tgt));
      rd(fdc_pkg::OFF_TRACK, 8'(tgt));
      rd(fdc_pkg::OFF_STATUS_CMD, 8'h00);
      ready <= 1'b0;
      acc(1'b1, fdc_pkg::OFF_STATUS_CMD, 8'h80, 1'b0);
      wait_hi(1'b1, 200);
      rd(fdc_pkg::OFF_STATUS_CMD, 8'h80);
      ready <= 1'b1;
      prot_n <= 1'b0;
      acc(1'b1, fdc_pkg::OFF_STATUS_CMD, 8'ha0, 1'b0);
      wait_hi(1'b1, 2000);
      rd(fdc_pkg::OFF_STATUS_CMD, 8'h40);
      prot_n <= 1'b1;
      acc(1'b1, fdc_pkg::OFF_DRIVE_CTRL, 8'ha5, 1'b0);
      xfer(8'h80);
      xfer(8'ha0);
      cmp({7'h00, fdc_drive_model_i.n_flux != 0}, 8'h01);
      results();
   end
   initial begin
      #1_800_000;
      error_cnt++;
      results();
   end
endmodule
